// ==== rtl/ign_seq_defs.svh ====
// Purpose: named constants for the ignition power sequencer
// Assumes: 125 MHz system clock, 1 ms delay tick
// Notes:   delay figures are in milliseconds
`ifndef IGN_SEQ_DEFS_SVH
`define IGN_SEQ_DEFS_SVH

`define CLK_PERIOD_NS   32'h0000_0008
`define TICK_PERIOD_NS  32'h000F_4240
`define TICK_CYCLES     (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_MS         32'h0000_0001
`define NS_PER_MS       32'h000F_4240
// host button press width, 200 ms
`define PULSE_MS        32'h0000_00C8
`define PULSE_CYCLES    (`PULSE_MS * `NS_PER_MS / `CLK_PERIOD_NS)

`define T_160MS         32'h0000_00A0
`define T_10S           32'h0000_2710
`define T_30S           32'h0000_7530
`define T_1MIN          32'h0000_EA60
`define T_3MIN          32'h0002_BF20
`define T_5MIN          32'h0004_93E0
`define T_10MIN         32'h0009_27C0
`define T_30MIN         32'h001B_7740
`define T_2H            32'h006D_DD00
`define T_NONE          32'h0000_0000
`define T_HARD_OFF      `T_10MIN
`define T_UNDERVOLT     `T_1MIN
`define T_BOOT_TIMEOUT  `T_1MIN
`define BOOT_RETRIES    4'h3
// synchroniser reset: front button idles high, mode reads reserved
`define SYNC_IDLE       9'h01F

`define MODE_ATX        4'h0
`define MODE_AT         4'h1
`define MODE_IGN_FIRST  4'h2
`define MODE_IGN_LAST   4'hE
`define MODE_SMART_A    4'hD
`define MODE_SMART_B    4'hE
`define MODE_RESERVED   4'hF

`endif

// ==== rtl/ign_seq_pkg.sv ====
// Purpose: types shared by the ignition power sequencer
// Assumes: nothing beyond the defs header
// Notes:   state codes are left to the tools
package ign_seq_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_ATX, S_ON_DELAY, S_RAIL_UP, S_PWR_ON, S_BOOT_WAIT,
        S_RUNNING, S_OFF_DELAY, S_OFF_PULSE, S_SHUT_WAIT, S_HALT
    } seq_state_t;
endpackage

// ==== rtl/ignition_power_sequencer.sv ====
// Purpose: ignition driven power sequencer for a host computer
// Assumes: always-on clock; all inputs are asynchronous pins
// Notes:   mode switch is latched while idle
// Notes on behaviour
// - with DC present, sample ignition each tick, idle with host rails off
// - ignition active while idle starts the selected power-on delay
// - power-on delay expiry turns on both standby rails
// - after rails are on, one low pulse on the host button line
// - ignition inactive while running starts the selected power-off delay
// - power-off delay expiry issues another button pulse for soft-off
// - host sensed off: drop both rails and return to idle
// - undervoltage held 60 s while operational shuts the host down
// - ignition lost during power-on delay: abandon, idle, no rails
// - ignition back during power-off delay: abandon, keep host running
// - host still on 10 minutes after off delay: force power off
// - modes 13 and 14 cut power at once if host stops during off delay
// - 4-bit switch selects modes 0 to 15; modes 2 to 14 each a delay pair
// - mode 0 ignores ignition; front button alone controls the host
// - mode 1 powers on with DC, no delay, retries failed boots
// - mode 2: 160 ms on, 160 ms off, 10 minute hard-off
// - modes 3-8: 10s/10s,10s/1m,10s/5m,30s/1m,30s/5m,30s/10m
// - modes 9-12: 3m/1m, 3m/10m, 3m/30m, 10m/30m
// - modes 13, 14: 30 s or 3 min on, 2 hours off
`timescale 1ns/1ps
`default_nettype none
`include "ign_seq_defs.svh"

module ignition_power_sequencer #(
    parameter int TICK_CYCLES  = `TICK_CYCLES,
    parameter int PULSE_CYCLES = `PULSE_CYCLES
) (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_n,
    // vehicle side
    input  wire logic       i_ignition_input,
    input  wire logic       i_dc_present,
    input  wire logic       i_undervoltage,
    input  wire logic [3:0] i_mode_switch,
    input  wire logic       i_front_button_n,
    // host side
    input  wire logic       i_host_on,
    output logic            o_host_power_button_n,
    output logic            o_standby_rail_low_en,
    output logic            o_standby_rail_high_en
);
    import ign_seq_pkg::*;

    // modes 0, 1 and 15 carry no delays
    function automatic logic [31:0] on_delay_ms(input logic [3:0] m);
        case (m)
            4'h2:                   on_delay_ms = `T_160MS;
            4'h3, 4'h4, 4'h5:       on_delay_ms = `T_10S;
            4'h6, 4'h7, 4'h8, 4'hD: on_delay_ms = `T_30S;
            4'h9, 4'hA, 4'hB, 4'hE: on_delay_ms = `T_3MIN;
            4'hC:                   on_delay_ms = `T_10MIN;
            default:                on_delay_ms = `T_NONE;
        endcase
    endfunction

    function automatic logic [31:0] off_delay_ms(input logic [3:0] m);
        case (m)
            4'h2:             off_delay_ms = `T_160MS;
            4'h3:             off_delay_ms = `T_10S;
            4'h4, 4'h6, 4'h9: off_delay_ms = `T_1MIN;
            4'h5, 4'h7:       off_delay_ms = `T_5MIN;
            4'h8, 4'hA:       off_delay_ms = `T_10MIN;
            4'hB, 4'hC:       off_delay_ms = `T_30MIN;
            4'hD, 4'hE:       off_delay_ms = `T_2H;
            default:          off_delay_ms = `T_NONE;
        endcase
    endfunction

    // pin synchronisers: ign, dc, uv, host, front, mode
    logic [8:0]  sync1_r;
    logic [8:0]  sync2_r;
    wire  [8:0]  pins = {i_ignition_input, i_dc_present, i_undervoltage,
                         i_host_on, i_front_button_n, i_mode_switch};
    wire         ign_s   = sync2_r[8];
    wire         dc_s    = sync2_r[7];
    wire         uv_s    = sync2_r[6];
    wire         host_s  = sync2_r[5];
    wire         front_s = sync2_r[4];
    wire  [3:0]  mode_s  = sync2_r[3:0];

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // idle levels, so no false press or mode 0 entry follows reset
            sync1_r <= `SYNC_IDLE;
            sync2_r <= `SYNC_IDLE;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    seq_state_t  state_r;
    seq_state_t  state_nxt;
    logic [31:0] tick_cnt_r;
    logic [31:0] cnt_r;
    logic [31:0] uv_cnt_r;
    logic [31:0] pulse_cnt_r;
    logic [3:0]  retry_r;
    logic [3:0]  mode_r;
    logic        ign_smp_r;
    logic        rail_r;
    logic        btn_n_r;

    // slow tick; delays resolve to one tick
    wire tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

    // setting 15 lies outside every decode, so it stays inert
    wire mode_ign   = (mode_r >= `MODE_IGN_FIRST) && (mode_r <= `MODE_IGN_LAST);
    wire mode_smart = (mode_r == `MODE_SMART_A) || (mode_r == `MODE_SMART_B);
    wire mode_at    = (mode_r == `MODE_AT);
    wire mode_atx   = (mode_r == `MODE_ATX);

    wire on_done    = cnt_r >= on_delay_ms(mode_r) / `TICK_MS;
    wire off_done   = cnt_r >= off_delay_ms(mode_r) / `TICK_MS;
    wire hard_done  = cnt_r >= `T_HARD_OFF / `TICK_MS;
    wire boot_done  = cnt_r >= `T_BOOT_TIMEOUT / `TICK_MS;
    wire operating  = (state_r == S_RUNNING) || (state_r == S_OFF_DELAY);
    wire uv_expired = operating && (uv_cnt_r >= `T_UNDERVOLT / `TICK_MS);
    wire pulse_last = (pulse_cnt_r == 32'h0000_0001);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (dc_s && mode_atx)
                    state_nxt = S_ATX;
                else if (dc_s && mode_at && !uv_s)
                    state_nxt = S_ON_DELAY;
                else if (dc_s && mode_ign && ign_smp_r)
                    state_nxt = S_ON_DELAY;
            end
            S_ATX:       state_nxt = S_ATX;
            S_ON_DELAY: begin
                if (mode_ign && !ign_smp_r)
                    state_nxt = S_IDLE;
                else if (on_done)
                    state_nxt = S_RAIL_UP;
            end
            S_RAIL_UP:   if (tick) state_nxt = S_PWR_ON;
            S_PWR_ON:    if (pulse_last) state_nxt = S_BOOT_WAIT;
            S_BOOT_WAIT: begin
                if (host_s)
                    state_nxt = S_RUNNING;
                else if (boot_done && mode_at && retry_r < `BOOT_RETRIES)
                    state_nxt = S_PWR_ON;
                else if (boot_done && mode_at)
                    state_nxt = S_HALT;
                else if (boot_done)
                    state_nxt = S_RUNNING;
            end
            S_RUNNING: begin
                if (!host_s)
                    state_nxt = S_IDLE;
                else if (uv_expired)
                    state_nxt = S_OFF_PULSE;
                else if (mode_ign && !ign_smp_r)
                    state_nxt = S_OFF_DELAY;
            end
            S_OFF_DELAY: begin
                if (ign_smp_r)
                    state_nxt = S_RUNNING;
                else if (mode_smart && !host_s)
                    state_nxt = S_IDLE;
                else if (uv_expired || off_done)
                    state_nxt = S_OFF_PULSE;
            end
            S_OFF_PULSE: if (pulse_last) state_nxt = S_SHUT_WAIT;
            S_SHUT_WAIT: begin
                if (!host_s || hard_done)
                    state_nxt = S_IDLE;
            end
            S_HALT:      state_nxt = S_HALT;
            default:     state_nxt = S_IDLE;
        endcase
        // losing DC drops everything; reserved setting never leaves idle
        if (!dc_s)
            state_nxt = S_IDLE;
    end

    wire entering   = (state_nxt != state_r);
    wire pulse_go   = entering && ((state_nxt == S_PWR_ON) || (state_nxt == S_OFF_PULSE));
    wire rails_nxt  = (state_nxt != S_IDLE) && (state_nxt != S_ON_DELAY)
                      && (state_nxt != S_HALT);
    wire [31:0] pulse_nxt = pulse_go ? 32'(PULSE_CYCLES) :
                            (pulse_cnt_r != 32'h0) ? pulse_cnt_r - 32'h1 : 32'h0;
    wire btn_nxt    = (state_nxt == S_ATX) ? front_s : (pulse_nxt == 32'h0);

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r     <= S_IDLE;
            tick_cnt_r  <= 32'h0;
            cnt_r       <= 32'h0;
            pulse_cnt_r <= 32'h0;
        end else begin
            state_r     <= state_nxt;
            tick_cnt_r  <= tick ? 32'h0 : tick_cnt_r + 32'h1;
            cnt_r       <= entering ? 32'h0 : cnt_r + {31'h0, tick};
            pulse_cnt_r <= pulse_nxt;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            uv_cnt_r  <= 32'h0;
            retry_r   <= 4'h0;
            mode_r    <= `MODE_RESERVED;
            ign_smp_r <= 1'b0;
            rail_r    <= 1'b0;
            btn_n_r   <= 1'b1;
        end else begin
            // restarts whenever the comparator clears
            uv_cnt_r  <= (uv_s && operating) ? uv_cnt_r + {31'h0, tick} : 32'h0;
            retry_r   <= (state_r == S_IDLE) ? 4'h0 :
                         (pulse_go && state_r == S_BOOT_WAIT) ? retry_r + 4'h1 : retry_r;
            mode_r    <= (state_r == S_IDLE) ? mode_s : mode_r;
            ign_smp_r <= tick ? ign_s : ign_smp_r;
            rail_r    <= rails_nxt;
            btn_n_r   <= btn_nxt;
        end
    end

    assign o_standby_rail_low_en  = rail_r;
    assign o_standby_rail_high_en = rail_r;
    assign o_host_power_button_n  = btn_n_r;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    // checks read the synchronised pins, as the logic does
    idle_rails_off_a: assert property (
        state_r == S_IDLE |-> !o_standby_rail_low_en && !o_standby_rail_high_en)
        else $error("rails on while idle");
    ign_start_a: assert property (
        state_r == S_IDLE && dc_s && mode_ign && ign_smp_r |=> state_r == S_ON_DELAY)
        else $error("ignition did not start power-on delay");
    rails_up_a: assert property (
        state_r == S_ON_DELAY && dc_s && on_done && !(mode_ign && !ign_smp_r)
        |=> state_r == S_RAIL_UP && o_standby_rail_low_en && o_standby_rail_high_en)
        else $error("rails not enabled after power-on delay");
    pulse_after_rail_a: assert property (
        $fell(o_host_power_button_n) && !mode_atx |-> $past(rail_r) && rail_r)
        else $error("button pulse before rails were up");
    pulse_end_a: assert property (
        pulse_last && state_r == S_PWR_ON && dc_s |=> o_host_power_button_n)
        else $error("button pulse not released");
    off_start_a: assert property (
        state_r == S_RUNNING && dc_s && host_s && !uv_expired && mode_ign && !ign_smp_r
        |=> state_r == S_OFF_DELAY)
        else $error("ignition loss did not start power-off delay");
    on_cancel_a: assert property (
        state_r == S_ON_DELAY && mode_ign && !ign_smp_r |=> state_r == S_IDLE ##1 !rail_r)
        else $error("power-on delay not abandoned");
    off_cancel_a: assert property (
        state_r == S_OFF_DELAY && dc_s && ign_smp_r |=> state_r == S_RUNNING && rail_r)
        else $error("power-off delay not abandoned");
    uv_shutdown_a: assert property (
        state_r == S_RUNNING && dc_s && host_s && uv_expired
        |=> state_r == S_OFF_PULSE && !o_host_power_button_n)
        else $error("undervoltage did not shut host down");
    hard_off_a: assert property (
        state_r == S_SHUT_WAIT && hard_done |=> state_r == S_IDLE ##1 !rail_r)
        else $error("hard-off did not remove power");
    smart_off_a: assert property (
        state_r == S_OFF_DELAY && mode_smart && !ign_smp_r && !host_s |=> !rail_r)
        else $error("smart off-delay did not cut power");
    reserved_a: assert property (
        state_r == S_IDLE && mode_r == `MODE_RESERVED && mode_s == `MODE_RESERVED
        |=> state_r == S_IDLE)
        else $error("reserved setting left idle");
    dc_loss_a: assert property (
        !dc_s |=> state_r == S_IDLE && !o_standby_rail_low_en)
        else $error("DC loss did not return to idle");
    at_start_a: assert property (
        state_r == S_IDLE && dc_s && mode_at && !uv_s |=> state_r == S_ON_DELAY)
        else $error("mode 1 did not start with DC");
    atx_front_a: assert property (
        state_r == S_ATX && dc_s |=> o_host_power_button_n == $past(front_s))
        else $error("button does not follow front button");
    off_pulse_a: assert property (
        state_r == S_OFF_DELAY && dc_s && !ign_smp_r && !(mode_smart && !host_s) && off_done
        |=> state_r == S_OFF_PULSE && !o_host_power_button_n)
        else $error("power-off delay expiry gave no pulse");
    retry_halt_a: assert property (
        state_r == S_BOOT_WAIT && dc_s && mode_at && !host_s && boot_done
        && retry_r >= `BOOT_RETRIES |=> state_r == S_HALT && !o_standby_rail_low_en)
        else $error("failed boots not bounded");

    cov_full_cycle_c: cover property (state_r == S_SHUT_WAIT ##1 state_r == S_IDLE);
    cov_on_cancel_c:  cover property (state_r == S_ON_DELAY ##1 state_r == S_IDLE);
    cov_off_cancel_c: cover property (state_r == S_OFF_DELAY ##1 state_r == S_RUNNING);
    cov_retry_c:      cover property (state_r == S_BOOT_WAIT ##1 state_r == S_PWR_ON);
    cov_atx_c:        cover property (state_r == S_IDLE ##1 state_r == S_ATX);
endmodule // ignition_power_sequencer
`default_nettype wire

// ==== sim/host_model.sv ====
// Purpose: behavioural host computer seen from the sequencer's host side
// Assumes: a released button press toggles the host; no standby rail means no host
// Notes:   i_slow stretches the boot and shutdown response to BOOT_DLY cycles
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int BOOT_DLY = 40
) (
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // sequencer side
    input  wire logic i_button_n,
    input  wire logic i_rail_en,
    input  wire logic i_slow,
    output logic      o_host_on
);
    logic btn_q_r = 1'b1;
    logic want_r  = 1'b0;
    int   wait_r  = 0;
    // a real host acts on the release of the press, not on the falling edge
    always @(posedge i_sys_clk) begin
        btn_q_r <= i_button_n;
        if (!i_reset_n || !i_rail_en) begin
            want_r    <= 1'b0;
            wait_r    <= 0;
            o_host_on <= 1'b0;
        end else if (i_button_n && !btn_q_r) begin
            want_r <= !want_r;
            wait_r <= i_slow ? BOOT_DLY : 2;
        end else if (wait_r > 1) begin
            wait_r <= wait_r - 1;
        end else if (wait_r == 1) begin
            o_host_on <= want_r;
            wait_r    <= 0;
        end
    end
endmodule // host_model
`default_nettype wire

// ==== sim/ignition_power_sequencer_tb.sv ====
// Purpose: self-checking bench for the ignition power sequencer
// Assumes: tick of 4 clocks, so a delay in ms is that many ticks
// Notes:   minute-long timers stay with the assertions inside the rtl
`timescale 1ns/1ps
`default_nettype none
module ignition_power_sequencer_tb;
    localparam int TICK  = 4;
    localparam int PULSE = 3;
    localparam int T2    = 160 * TICK;
    localparam int BTN   = 0;
    localparam int RAIL  = 1;
    localparam int HOST  = 2;
    logic       clk      = 1'b0;
    logic       rst_n    = 1'b0;
    logic       ign      = 1'b0;
    logic       dc       = 1'b1;
    logic       uv       = 1'b0;
    logic [3:0] sw       = 4'hF;
    logic       front_n  = 1'b1;
    logic       slow     = 1'b0;
    logic       btn_n;
    logic       rail_lo;
    logic       rail_hi;
    logic       host_on;
    int         errors   = 0;
    int         compares = 0;
    int         n;
    always #4 clk = ~clk;

    ignition_power_sequencer #(.TICK_CYCLES(TICK), .PULSE_CYCLES(PULSE))
        i_ignition_power_sequencer (.i_sys_clk(clk), .i_reset_n(rst_n),
        .i_ignition_input(ign), .i_dc_present(dc), .i_undervoltage(uv),
        .i_mode_switch(sw), .i_front_button_n(front_n), .i_host_on(host_on),
        .o_host_power_button_n(btn_n), .o_standby_rail_low_en(rail_lo),
        .o_standby_rail_high_en(rail_hi));
    host_model i_host_model (.i_sys_clk(clk), .i_reset_n(rst_n), .i_button_n(btn_n),
        .i_rail_en(rail_lo), .i_slow(slow), .o_host_on(host_on));

    function automatic logic pick(input int sel);
        return (sel == BTN) ? btn_n : (sel == RAIL) ? rail_lo : host_on;
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // n ends above lim when the level never came
    task automatic wait_for(input int sel, input logic v, input int lim, output int k);
        k = 0;
        while (pick(sel) !== v && k <= lim) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // dc loss forces idle so the new setting is latched
    task automatic set_mode(input logic [3:0] m);
        dc = 1'b0;
        ign = 1'b0;
        cyc(10);
        sw = m;
        cyc(20);
        dc = 1'b1;
        cyc(4);
    endtask
    task automatic power_up();
        ign = 1'b1;
        wait_for(RAIL, 1'b1, T2 + 40, n);
        check("on delay clocks", n >= T2 && n <= T2 + 24, 1);
        check("rails paired", rail_hi, 1'b1);
        wait_for(BTN, 1'b0, 8, n);
        check("pulse after rails", n >= 1 && n <= TICK, 1);
        wait_for(BTN, 1'b1, 8, n);
        check("on pulse width", n, PULSE);
        wait_for(HOST, 1'b1, 100, n);
    endtask
    task automatic power_down();
        ign = 1'b0;
        wait_for(BTN, 1'b0, T2 + 40, n);
        check("off delay clocks", n >= T2 && n <= T2 + 24, 1);
        wait_for(BTN, 1'b1, 8, n);
        check("off pulse width", n, PULSE);
        wait_for(RAIL, 1'b0, 80, n);
        check("rails drop after host off", n <= 80 && rail_hi === 1'b0, 1);
    endtask
    task automatic t_idle_reserved();
        check("idle rail", {rail_hi, rail_lo, btn_n}, 3'h1);
        ign = 1'b1;
        wait_for(RAIL, 1'b1, 1200, n);
        check("reserved mode inert", n > 1200 && btn_n === 1'b1, 1);
        $display("done: idle and reserved");
    endtask
    task automatic t_full_cycle();
        set_mode(4'h2);
        power_up();
        power_down();
        $display("done: full cycle");
    endtask
    task automatic t_on_cancel();
        ign = 1'b1;
        cyc(200);
        ign = 1'b0;
        wait_for(RAIL, 1'b1, 1200, n);
        check("on delay abandoned", n > 1200, 1);
        $display("done: on cancel");
    endtask
    task automatic t_off_cancel();
        slow = 1'b1;
        power_up();
        ign = 1'b0;
        cyc(200);
        ign = 1'b1;
        wait_for(BTN, 1'b0, 1200, n);
        check("off delay abandoned", n > 1200, 1);
        check("host kept", {rail_lo, host_on}, 2'h3);
        power_down();
        slow = 1'b0;
        $display("done: off cancel");
    endtask
    task automatic t_long_mode();
        set_mode(4'h3);
        ign = 1'b1;
        wait_for(RAIL, 1'b1, 1200, n);
        check("mode 3 on delay past 300 ticks", n > 1200 && btn_n === 1'b1, 1);
        ign = 1'b0;
        $display("done: long mode");
    endtask
    task automatic t_at_mode();
        set_mode(4'h1);
        wait_for(RAIL, 1'b1, 40, n);
        check("at mode rails at once", n <= 40, 1);
        wait_for(HOST, 1'b1, 100, n);
        check("at mode host up", host_on, 1'b1);
        $display("done: at mode");
    endtask
    task automatic t_atx_mode();
        set_mode(4'h0);
        ign = 1'b1;
        cyc(60);
        check("atx ignores ignition", {rail_lo, btn_n}, 2'h3);
        front_n = 1'b0;
        wait_for(BTN, 1'b0, 8, n);
        check("button follows front", n <= 4, 1);
        front_n = 1'b1;
        wait_for(HOST, 1'b1, 100, n);
        check("atx host up", host_on, 1'b1);
        $display("done: atx mode");
    endtask

    initial begin
        cyc(8);
        rst_n = 1'b1;
        cyc(10);
        t_idle_reserved();
        t_full_cycle();
        t_on_cancel();
        t_off_cancel();
        t_long_mode();
        t_at_mode();
        t_atx_mode();
        finish_test();
    end
    // the whole run needs about 8k cycles
    initial begin
        #(8 * 60000);
        errors++;
        finish_test();
    end
endmodule // ignition_power_sequencer_tb
`default_nettype wire
